//--- common/irqc_ifs.sv
`timescale 1ns/100ps
// ----------------------------------------
// Link between the register logic and one posted bank
// ----------------------------------------
interface bank_if #(parameter int W = 8);
	logic [W-1:0] hw_evt;   // Hardware raise, one bit per source
	logic         wr;       // Write strobe to the clear register
	logic [W-1:0] wdata;    // Write data
	logic         sw_en;    // Soft interrupt enable
	logic [W-1:0] posted;   // Posted state
	modport ctrl (output hw_evt, wr, wdata, sw_en, input posted);
	modport bank (input hw_evt, wr, wdata, sw_en, output posted);
endinterface // bank_if
// ----------------------------------------
// Link between the register logic and the event block
// ----------------------------------------
interface evt_if;
	import irqc_pkg::*;
	logic [EVT_W-1:0] evt;      // Event pulses
	logic             st_wr;    // Status write, one clears
	logic             mk_wr;    // Mask write
	logic [EVT_W-1:0] wdata;    // Write data
	logic [EVT_W-1:0] status;   // Sticky status
	logic [EVT_W-1:0] mask;     // Mask
	logic             irq;      // Level interrupt
	modport ctrl (output evt, st_wr, mk_wr, wdata, input status, mask, irq);
	modport unit (input evt, st_wr, mk_wr, wdata, output status, mask, irq);
endinterface // evt_if

//--- common/irqc_pkg.sv
package irqc_pkg;
	// ----------------------------------------
	// Bus widths and answers
	// ----------------------------------------
	localparam int         DATA_W     = 32;          // Bus data width
	localparam int         ADDR_W     = 32;          // Bus address width
	localparam logic [1:0] HTRANS_NSQ = 2'h2;        // NONSEQ transfer
	localparam logic       HRESP_OKAY = 1'h0;        // Always OKAY
	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [7:0] IDX_CLR1   = 8'hdb;       // posted_irq_clear_1
	localparam logic [7:0] IDX_CLR2   = 8'hdc;       // posted_irq_clear_2
	localparam logic [7:0] IDX_MSK2   = 8'hde;       // irq_mask_2
	localparam logic [7:0] IDX_MSK1   = 8'hdf;       // irq_mask_1
	localparam logic [7:0] IDX_SWEN   = 8'he1;       // Soft interrupt enable
	localparam logic [7:0] IDX_EVST   = 8'hf0;       // Event status, write one clears
	localparam logic [7:0] IDX_EVMK   = 8'hf1;       // Event mask
	// ----------------------------------------
	// Field layout
	// ----------------------------------------
	localparam int GRP1_W      = 8;                  // Sources in clear register 1
	localparam int GRP2_W      = 6;                  // Sources in clear register 2
	localparam int POS_FIRST_TIMER_IRQ  = 0;                  // first_timer_irq
	localparam int POS_SECOND_TIMER_IRQ  = 1;                  // second_timer_irq
	localparam int POS_BUS_RST = 2;                  // USB bus reset
	localparam int POS_SOF     = 3;                  // USB start of frame
	localparam int POS_EP0     = 4;                  // usb_ep0_irq, ep1..3 follow
	localparam int POS_EP4     = 0;                  // usb_ep4_irq, ep5..8 follow
	localparam int POS_WAKE    = 5;                  // USB wake
	localparam int POS_SWEN    = 0;                  // soft_irq_enable bit
	localparam int EVT_W       = 2;                  // Block event count
	localparam int EVT_GRP1    = 0;                  // New pending in group 1
	localparam int EVT_GRP2    = 1;                  // New pending in group 2
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [GRP1_W-1:0] RST_GRP1 = 8'h00;  // Mask and last pending, group 1
	localparam logic [GRP2_W-1:0] RST_GRP2 = 6'h00;  // Mask and last pending, group 2
	localparam logic              RST_SWEN = 1'h0;   // Software posting off
	localparam logic [EVT_W-1:0]  RST_EVT  = 2'h0;   // Event status and mask
	// ----------------------------------------
	// Bus phase state
	// ----------------------------------------
	typedef enum logic [2:0] {
		PH_IDLE  = 3'b001,
		PH_WRITE = 3'b010,
		PH_READ  = 3'b100
	} bus_phase_e;
endpackage

//--- hw/event_irq.sv
`timescale 1ns/100ps
module event_irq (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Register side
	evt_if.unit      bus
);
	import irqc_pkg::*;
	typedef struct packed {
		logic [EVT_W-1:0] status;   // Sticky event bits
		logic [EVT_W-1:0] mask;     // One lets an event interrupt
	} evt_state_s;
	evt_state_s st_r;               // Registered state
	evt_state_s st_nxt;             // Next state
	// ----------------------------------------
	// Sticky status, write one clears, set wins
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		if (bus.st_wr) begin
			st_nxt.status = st_r.status & ~bus.wdata;
		end
		st_nxt.status = st_nxt.status | bus.evt;
		if (bus.mk_wr) begin
			st_nxt.mask = bus.wdata;
		end
	end
	// Register the state
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_r.status <= RST_EVT;
			st_r.mask   <= RST_EVT;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign bus.status = st_r.status;
	assign bus.mask   = st_r.mask;
	assign bus.irq    = |(st_r.status & st_r.mask);
endmodule // event_irq

//--- hw/irq_post_ctrl.sv
`timescale 1ns/100ps
// Operation
// RULE1 - Read of clear register shows posted bits
// RULE2 - Zero write, posting off, clears posted bit
// RULE3 - Clearing absent interrupt changes nothing
// RULE4 - One write, posting on, posts interrupt
// RULE5 - One write, posting off, no effect
// RULE6 - Zero write, posting on, no effect
// RULE7 - Register 1 maps ep0, SOF, reset, timers
// RULE8 - Register 2 maps wake and endpoints 8..4
// RULE9 - Software writes zero to reserved bits 7:6
// RULE10 - Mask one allows pending, zero stops it
// RULE11 - Masked sources still post and clear
// RULE12 - Mask clear never alters posted state
// RULE13 - Mask 2 covers wake and endpoints 8..4
// RULE14 - Soft enable bit 0, resets zero
// RULE15 - Pending equals posted and mask, each cycle
// RULE16 - Hardware raise beats simultaneous clear
module irq_post_ctrl (
	// Clock and reset
	input  wire logic                          clk_in,
	input  wire logic                          rst_in,
	// AHB-Lite slave
	input  wire logic                          hsel_in,
	input  wire logic [irqc_pkg::ADDR_W-1:0]   haddr_in,
	input  wire logic [1:0]                    htrans_in,
	input  wire logic                          hwrite_in,
	input  wire logic [2:0]                    hsize_in,
	input  wire logic [irqc_pkg::DATA_W-1:0]   hwdata_in,
	input  wire logic                          hready_in,
	output logic      [irqc_pkg::DATA_W-1:0]   hrdata_out,
	output logic                               hreadyout_out,
	output logic                               hresp_out,
	// Hardware interrupt sources, one-cycle raises
	input  wire logic                          first_timer_irq_in,
	input  wire logic                          second_timer_irq_in,
	input  wire logic                          usb_bus_rst_irq_in,
	input  wire logic                          usb_sof_irq_in,
	input  wire logic [8:0]                    usb_ep_irq_in,
	input  wire logic                          usb_wake_irq_in,
	// Shared vectors
	output logic [irqc_pkg::GRP1_W+irqc_pkg::GRP2_W-1:0] posted_out,
	output logic [irqc_pkg::GRP1_W+irqc_pkg::GRP2_W-1:0] mask_out,
	output logic [irqc_pkg::GRP1_W+irqc_pkg::GRP2_W-1:0] pending_out,
	// Block interrupt
	output logic                               irq_out
);
	import irqc_pkg::*;
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		bus_phase_e          phase;     // Data phase kind
		logic [7:0]          idx;       // Register index of data phase
		logic [DATA_W-1:0]   rdata;     // Read data register
		logic [GRP1_W-1:0]   mask1;     // Group 1 mask
		logic [GRP2_W-1:0]   mask2;     // Group 2 mask
		logic                sw_en;     // soft_irq_enable
		logic [GRP1_W-1:0]   pend1;     // Last pending, group 1
		logic [GRP2_W-1:0]   pend2;     // Last pending, group 2
	} ctrl_state_s;
	ctrl_state_s st_r;                  // Registered state
	ctrl_state_s st_nxt;                // Next state
	// ----------------------------------------
	// Sub-block links
	// ----------------------------------------
	bank_if #(.W(GRP1_W)) b1 ();        // Clear register 1 bank
	bank_if #(.W(GRP2_W)) b2 ();        // Clear register 2 bank
	evt_if                ev ();        // Event status block
	posted_bank #(.W(GRP1_W)) u_bank1 (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.bus    (b1.bank)
	);
	posted_bank #(.W(GRP2_W)) u_bank2 (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.bus    (b2.bank)
	);
	event_irq u_evt (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.bus    (ev.unit)
	);
	// ----------------------------------------
	// Address phase decode
	// ----------------------------------------
	logic       take;       // Transfer accepted this edge
	logic       in_map;     // Address in the word-aligned window
	logic [7:0] a_idx;      // Index of the address phase
	logic       wr_ph;      // Write data phase now
	logic [GRP1_W-1:0] pnd1; // Current pending, group 1
	logic [GRP2_W-1:0] pnd2; // Current pending, group 2
	assign take   = hsel_in && hready_in && htrans_in == HTRANS_NSQ;
	assign in_map = haddr_in[ADDR_W-1:10] == '0 && haddr_in[1:0] == 2'h0;
	assign a_idx  = haddr_in[9:2];
	assign wr_ph  = st_r.phase == PH_WRITE;
	// ----------------------------------------
	// Source wiring
	// ----------------------------------------
	// Hardware raises placed at their bit positions
	always_comb begin
		b1.hw_evt = '0;
		b1.hw_evt[POS_FIRST_TIMER_IRQ]  = first_timer_irq_in;          // RULE7
		b1.hw_evt[POS_SECOND_TIMER_IRQ]  = second_timer_irq_in;         // RULE7
		b1.hw_evt[POS_BUS_RST] = usb_bus_rst_irq_in;          // RULE7
		b1.hw_evt[POS_SOF]     = usb_sof_irq_in;              // RULE7
		b1.hw_evt[POS_EP0+:4]  = usb_ep_irq_in[3:0];          // RULE7
		b2.hw_evt = '0;
		b2.hw_evt[POS_EP4+:5]  = usb_ep_irq_in[8:4];          // RULE8
		b2.hw_evt[POS_WAKE]    = usb_wake_irq_in;             // RULE8
	end
	// Write strobes reach the banks during the data phase
	always_comb begin
		b1.wr    = wr_ph && st_r.idx == IDX_CLR1;
		b2.wr    = wr_ph && st_r.idx == IDX_CLR2;
		b1.wdata = hwdata_in[GRP1_W-1:0];
		b2.wdata = hwdata_in[GRP2_W-1:0];                     // RULE9
		b1.sw_en = st_r.sw_en;
		b2.sw_en = st_r.sw_en;
	end
	// ----------------------------------------
	// Pending vectors
	// ----------------------------------------
	// Masks gate posted bits only; posted state is untouched
	assign pnd1 = b1.posted & st_r.mask1;                     // RULE10 RULE15
	assign pnd2 = b2.posted & st_r.mask2;                     // RULE13 RULE15
	// Event block hookup: newly pending bits per group
	always_comb begin
		ev.evt           = '0;
		ev.evt[EVT_GRP1] = |(pnd1 & ~st_r.pend1);
		ev.evt[EVT_GRP2] = |(pnd2 & ~st_r.pend2);
		ev.st_wr         = wr_ph && st_r.idx == IDX_EVST;
		ev.mk_wr         = wr_ph && st_r.idx == IDX_EVMK;
		ev.wdata         = hwdata_in[EVT_W-1:0];
	end
	// ----------------------------------------
	// Register file and bus phase
	// ----------------------------------------
	always_comb begin
		st_nxt       = st_r;
		st_nxt.pend1 = pnd1;
		st_nxt.pend2 = pnd2;
		// Data phase writes to registers held here
		if (wr_ph) begin
			if (st_r.idx == IDX_MSK1) begin
				st_nxt.mask1 = hwdata_in[GRP1_W-1:0];                // RULE10 RULE12
			end else if (st_r.idx == IDX_MSK2) begin
				st_nxt.mask2 = hwdata_in[GRP2_W-1:0];                // RULE13 RULE9
			end else if (st_r.idx == IDX_SWEN) begin
				st_nxt.sw_en = hwdata_in[POS_SWEN];                  // RULE14
			end
		end
		// Accept a new address phase
		st_nxt.phase = PH_IDLE;
		st_nxt.rdata = '0;
		if (take) begin
			st_nxt.idx   = in_map ? a_idx : 8'h00;
			st_nxt.phase = hwrite_in ? PH_WRITE : PH_READ;
			if (!hwrite_in && in_map) begin
				// Read data latched at address phase; unmapped reads zero
				if (a_idx == IDX_CLR1) begin
					st_nxt.rdata[GRP1_W-1:0] = b1.posted;                // RULE1 RULE11
				end else if (a_idx == IDX_CLR2) begin
					st_nxt.rdata[GRP2_W-1:0] = b2.posted;                // RULE1 RULE11
				end else if (a_idx == IDX_MSK1) begin
					st_nxt.rdata[GRP1_W-1:0] = st_r.mask1;
				end else if (a_idx == IDX_MSK2) begin
					st_nxt.rdata[GRP2_W-1:0] = st_r.mask2;
				end else if (a_idx == IDX_SWEN) begin
					st_nxt.rdata[POS_SWEN] = st_r.sw_en;                 // RULE14
				end else if (a_idx == IDX_EVST) begin
					st_nxt.rdata[EVT_W-1:0] = ev.status;
				end else if (a_idx == IDX_EVMK) begin
					st_nxt.rdata[EVT_W-1:0] = ev.mask;
				end
			end
		end
	end
	// Register the state
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_r.phase <= PH_IDLE;
			st_r.idx   <= 8'h00;
			st_r.rdata <= '0;
			st_r.mask1 <= RST_GRP1;
			st_r.mask2 <= RST_GRP2;
			st_r.sw_en <= RST_SWEN;                                  // RULE14
			st_r.pend1 <= RST_GRP1;
			st_r.pend2 <= RST_GRP2;
		end else begin
			st_r <= st_nxt;
		end
	end
	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign hrdata_out    = st_r.rdata;
	assign hreadyout_out = 1'b1;
	assign hresp_out     = HRESP_OKAY;
	assign posted_out    = {b2.posted, b1.posted};
	assign mask_out      = {st_r.mask2, st_r.mask1};
	assign pending_out   = {pnd2, pnd1};
	assign irq_out       = ev.irq;
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	property p_read_posted;
		take && !hwrite_in && in_map && a_idx == IDX_CLR1
			|=> hrdata_out == {{(DATA_W-GRP1_W){1'b0}}, $past(b1.posted)};
	endproperty
	a_read_posted: assert property (p_read_posted) else $error("clear 1 read wrong"); // RULE1
	property p_pend;
		pending_out == (posted_out & mask_out);
	endproperty
	a_pend: assert property (p_pend) else $error("pending not posted and mask"); // RULE15
	// A zero mask 1 write must silence the whole of group 1 on the next cycle
	property p_masked_quiet;
		wr_ph && st_r.idx == IDX_MSK1 && hwdata_in[GRP1_W-1:0] == '0
			|=> pending_out[GRP1_W-1:0] == '0;
	endproperty
	a_masked_quiet: assert property (p_masked_quiet) else $error("masked bit pending"); // RULE10
	property p_mask_keeps;
		wr_ph && st_r.idx == IDX_MSK2 && b2.hw_evt == '0 |=> $stable(b2.posted);
	endproperty
	a_mask_keeps: assert property (p_mask_keeps) else $error("mask write moved posted"); // RULE12
	property p_swen;
		wr_ph && st_r.idx == IDX_SWEN |=> st_r.sw_en == $past(hwdata_in[POS_SWEN]);
	endproperty
	a_swen: assert property (p_swen) else $error("soft enable not written"); // RULE14
	property p_wake_map;
		usb_wake_irq_in |=> posted_out[GRP1_W+POS_WAKE];
	endproperty
	a_wake_map: assert property (p_wake_map) else $error("wake not posted"); // RULE8
	property p_timer_map;
		first_timer_irq_in ##0 !second_timer_irq_in |=> posted_out[POS_FIRST_TIMER_IRQ];
	endproperty
	a_timer_map: assert property (p_timer_map) else $error("timer 1 not posted"); // RULE7
	// A masked wake raise still posts but never turns pending
	property p_masked_posts;
		usb_wake_irq_in && !mask_out[GRP1_W+POS_WAKE] && !(wr_ph && st_r.idx == IDX_MSK2)
			|=> posted_out[GRP1_W+POS_WAKE] && !pending_out[GRP1_W+POS_WAKE];
	endproperty
	a_masked_posts: assert property (p_masked_posts) else $error("masked raise lost"); // RULE11
	property p_mask2_read;
		take && !hwrite_in && in_map && a_idx == IDX_MSK2
			|=> hrdata_out[DATA_W-1:GRP2_W] == '0;
	endproperty
	a_mask2_read: assert property (p_mask2_read) else $error("reserved bits read one"); // RULE13
endmodule // irq_post_ctrl

//--- hw/posted_bank.sv
`timescale 1ns/100ps
module posted_bank #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Register side
	bank_if.bank     bus
);
	import irqc_pkg::*;
	typedef struct packed {
		logic [W-1:0] posted;   // Posted interrupt per source
	} bank_state_s;
	bank_state_s st_r;          // Registered state
	bank_state_s st_nxt;        // Next state
	logic [W-1:0] clr;          // Clearing bits of this write
	logic [W-1:0] set;          // Posting bits of this write
	// ----------------------------------------
	// Clear and post
	// ----------------------------------------
	// Zero bits clear only with posting off, one bits post only with it on
	always_comb begin
		clr = (bus.wr && !bus.sw_en) ? ~bus.wdata : '0; // RULE2 RULE5
		set = (bus.wr && bus.sw_en) ? bus.wdata : '0;   // RULE4 RULE6
		st_nxt = st_r;
		// Hardware raise wins over a clear in the same cycle
		st_nxt.posted = (st_r.posted & ~clr) | set | bus.hw_evt; // RULE16 RULE3
	end
	// Register the state
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_r.posted <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign bus.posted = st_r.posted;
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	property p_zero_clears;
		bus.wr && !bus.sw_en && bus.hw_evt == '0 |=> (bus.posted & ~$past(bus.wdata)) == '0;
	endproperty
	a_zero_clears: assert property (p_zero_clears) else $error("zero write did not clear"); // RULE2
	property p_one_posts;
		bus.wr && bus.sw_en |=> (bus.posted & $past(bus.wdata)) == $past(bus.wdata);
	endproperty
	a_one_posts: assert property (p_one_posts) else $error("one write did not post"); // RULE4
	property p_no_post_off;
		bus.wr && !bus.sw_en && bus.hw_evt == '0 |=> (bus.posted & ~$past(bus.posted)) == '0;
	endproperty
	a_no_post_off: assert property (p_no_post_off) else $error("post without enable"); // RULE5
	property p_zero_keeps;
		bus.wr && bus.sw_en |=> (bus.posted & $past(bus.posted)) == $past(bus.posted);
	endproperty
	a_zero_keeps: assert property (p_zero_keeps) else $error("posting write cleared"); // RULE6
	property p_hw_wins;
		(bus.hw_evt != '0) |=> (bus.posted & $past(bus.hw_evt)) == $past(bus.hw_evt);
	endproperty
	a_hw_wins: assert property (p_hw_wins) else $error("hardware raise lost"); // RULE16
	property p_idle_still;
		!bus.wr && bus.hw_evt == '0 |=> $stable(bus.posted);
	endproperty
	a_idle_still: assert property (p_idle_still) else $error("posted moved alone"); // RULE3
endmodule // posted_bank

//--- test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import irqc_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic                     clk_in;         // System clock
	logic                     rst_in;         // Synchronous reset
	logic                     hsel_in;        // Slave select
	logic [ADDR_W-1:0]        haddr_in;       // Byte address
	logic [1:0]               htrans_in;      // Transfer kind
	logic                     hwrite_in;      // Write flag
	logic [2:0]               hsize_in;       // Always a word
	logic [DATA_W-1:0]        hwdata_in;      // Write data
	logic [DATA_W-1:0]        hrdata_out;     // Read data
	logic                     hreadyout_out;  // Slave ready, also bus ready
	logic                     hresp_out;      // Response
	logic [GRP1_W+GRP2_W-1:0] posted_out;     // Posted vector
	logic [GRP1_W+GRP2_W-1:0] mask_out;       // Mask vector
	logic [GRP1_W+GRP2_W-1:0] pending_out;    // Pending vector
	logic                     irq_out;        // Block interrupt
	logic [13:0]              src;            // Raises, posted-vector layout
	logic [13:0]              exp_posted;     // Expected posted state
	logic [13:0]              exp_mask;       // Expected mask state
	logic                     exp_swen;       // Expected soft enable
	logic                     dp_wr;          // Write data phase in flight
	logic [31:0]              dp_addr;        // Address of that write
	logic                     run_chk;        // Cycle monitor on
	logic [31:0]              regs [7];       // Mapped byte addresses
	logic [31:0]              a;              // Scratch address
	logic [31:0]              d;              // Scratch data
	int                       num_errors;     // Mismatches
	int                       n_checks;       // Comparisons
	// ----------------------------------------
	// Design and clock
	// ----------------------------------------
	irq_post_ctrl DUT (
		.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
		.htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
		.hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
		.hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
		.first_timer_irq_in(src[0]), .second_timer_irq_in(src[1]),
		.usb_bus_rst_irq_in(src[2]), .usb_sof_irq_in(src[3]),
		.usb_ep_irq_in({src[12:8], src[7:4]}), .usb_wake_irq_in(src[13]),
		.posted_out(posted_out), .mask_out(mask_out), .pending_out(pending_out),
		.irq_out(irq_out)
	);
	always #5 clk_in = ~clk_in;
	// ----------------------------------------
	// Expectation helpers
	// ----------------------------------------
	// Byte address of a register index
	function automatic logic [31:0] ba(input logic [7:0] i);
		return {22'h0, i, 2'b00};
	endfunction
	// Read value expected at an address
	function automatic logic [31:0] exp_rd(input logic [31:0] x);
		if (x == ba(IDX_CLR1)) return {24'h0, exp_posted[7:0]};
		if (x == ba(IDX_CLR2)) return {26'h0, exp_posted[13:8]};
		if (x == ba(IDX_MSK1)) return {24'h0, exp_mask[7:0]};
		if (x == ba(IDX_MSK2)) return {26'h0, exp_mask[13:8]};
		if (x == ba(IDX_SWEN)) return {31'h0, exp_swen};
		return 32'h0;
	endfunction
	// Register effect of a completed write
	task automatic model_write(input logic [31:0] x, input logic [31:0] w);
		if (x == ba(IDX_CLR1))
			exp_posted[7:0] = exp_swen ? (exp_posted[7:0] | w[7:0]) : (exp_posted[7:0] & w[7:0]);
		else if (x == ba(IDX_CLR2))
			exp_posted[13:8] = exp_swen ? (exp_posted[13:8] | w[5:0]) : (exp_posted[13:8] & w[5:0]);
		else if (x == ba(IDX_MSK1)) exp_mask[7:0] = w[7:0];
		else if (x == ba(IDX_MSK2)) exp_mask[13:8] = w[5:0];
		else if (x == ba(IDX_SWEN)) exp_swen = w[0];
	endtask
	// Reference model, stepped at each edge; raises applied after writes
	always @(posedge clk_in) begin
		if (rst_in) begin
			exp_posted = 14'h0;
			exp_mask = 14'h0;
			exp_swen = 1'b0;
			dp_wr = 1'b0;
		end else begin
			if (dp_wr) model_write(dp_addr, hwdata_in);
			exp_posted = exp_posted | src;
			dp_wr = hsel_in && hready_in_w() && (htrans_in === HTRANS_NSQ) && hwrite_in;
			dp_addr = haddr_in;
		end
	end
	function automatic logic hready_in_w();
		return hreadyout_out;
	endfunction
	// Cycle monitor of the shared vectors
	always @(negedge clk_in) begin
		if (run_chk && !rst_in) begin
			n_checks++;
			if ({posted_out, mask_out, pending_out} !== {exp_posted, exp_mask, exp_posted & exp_mask}) begin
				num_errors++;
				$display("ERROR %0t: vectors p %h m %h q %h", $time, posted_out, mask_out, pending_out);
			end
		end
	end
	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] e, input string m);
		n_checks++;
		if (got !== e) begin
			num_errors++;
			$display("ERROR %0t: %s got %h exp %h", $time, m, got, e);
		end
	endtask
	// Wait for ready at a rising edge, bounded
	task automatic wait_rdy;
		int k;
		k = 0;
		do begin
			@(posedge clk_in);
			k++;
		end while (hreadyout_out !== 1'b1 && k < 20);
		if (hreadyout_out !== 1'b1) begin
			num_errors++;
			$display("ERROR %0t: bus wait timed out", $time);
			finish_test();
		end
	endtask
	// One single word transfer
	task automatic ahb(input logic w, input logic [31:0] x, input logic [31:0] wd,
			output logic [31:0] r);
		@(posedge clk_in);
		hsel_in <= 1'b1;
		htrans_in <= HTRANS_NSQ;
		haddr_in <= x;
		hwrite_in <= w;
		wait_rdy();
		htrans_in <= 2'h0;
		hwdata_in <= wd;
		wait_rdy();
		r = hrdata_out;
		chk({31'h0, hresp_out}, {31'h0, HRESP_OKAY}, "response");
	endtask
	task automatic wr(input logic [31:0] x, input logic [31:0] w);
		logic [31:0] r;
		ahb(1'b1, x, w, r);
	endtask
	task automatic rd_chk(input logic [31:0] x, input logic [31:0] e, input string m);
		logic [31:0] r;
		ahb(1'b0, x, 32'h0, r);
		chk(r, e, m);
	endtask
	// Raise sources in the data phase of a transfer begun at the same time
	task automatic raise_at(input logic [13:0] v);
		repeat (2) @(posedge clk_in);
		src <= v;
		@(posedge clk_in);
		src <= 14'h0;
	endtask
	task automatic do_reset;
		@(posedge clk_in);
		rst_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
	endtask
	task automatic finish_test;
		$display("Checks %0d, errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		clk_in = 0; rst_in = 1; hsel_in = 0; haddr_in = 0; htrans_in = 0; hwrite_in = 0;
		hsize_in = 3'h2; hwdata_in = 0; src = 0; num_errors = 0; n_checks = 0; run_chk = 0;
		regs = '{ba(IDX_CLR1), ba(IDX_CLR2), ba(IDX_MSK1), ba(IDX_MSK2), ba(IDX_SWEN),
			ba(IDX_EVST), ba(IDX_EVMK)};
		void'($urandom(32'h484afe1a));
		do_reset();
		run_chk = 1;
		// Reset values and an unmapped place
		foreach (regs[i]) rd_chk(regs[i], 32'h0, "reset value");
		rd_chk(32'h0, 32'h0, "unmapped");
		$display("TEST reset done");
		// Posting, clearing and no-effect writes
		wr(ba(IDX_SWEN), 32'h1);
		wr(ba(IDX_CLR1), 32'h5a);
		rd_chk(ba(IDX_CLR1), 32'h5a, "post");
		wr(ba(IDX_CLR1), 32'h0);
		rd_chk(ba(IDX_CLR1), 32'h5a, "zero while posting");
		wr(ba(IDX_SWEN), 32'h0);
		rd_chk(ba(IDX_SWEN), 32'h0, "enable off");
		wr(ba(IDX_CLR1), 32'hff);
		rd_chk(ba(IDX_CLR1), 32'h5a, "one while clearing");
		wr(ba(IDX_CLR1), 32'h0f);
		rd_chk(ba(IDX_CLR1), 32'h0a, "clear");
		wr(ba(IDX_MSK1), 32'hff);
		wr(ba(IDX_MSK1), 32'h0);
		rd_chk(ba(IDX_CLR1), 32'h0a, "mask keeps posted");
		wr(ba(IDX_MSK2), 32'h21);
		rd_chk(ba(IDX_MSK2), 32'h21, "mask 2");
		fork
			wr(ba(IDX_CLR1), 32'h0);
			raise_at(14'h2);
		join
		rd_chk(ba(IDX_CLR1), 32'h02, "raise beats clear");
		wr(ba(IDX_CLR1), 32'h0);
		$display("TEST directed done");
		// Each source lands in its own bit
		for (int i = 0; i < 14; i++) begin
			@(posedge clk_in);
			src <= 14'h1 << i;
			@(posedge clk_in);
			src <= 14'h0;
			d = 32'h1 << i;
			rd_chk(ba(IDX_CLR1), {24'h0, d[7:0]}, "map 1");
			rd_chk(ba(IDX_CLR2), {26'h0, d[13:8]}, "map 2");
			wr(ba(IDX_CLR1), 32'h0);
			wr(ba(IDX_CLR2), 32'h0);
		end
		$display("TEST mapping done");
		// Event interrupt: raise, mask, clear
		wr(ba(IDX_MSK1), 32'hff);
		wr(ba(IDX_EVMK), 32'h0);
		wr(ba(IDX_EVST), 32'h3);
		@(posedge clk_in);
		src <= 14'h1;
		@(posedge clk_in);
		src <= 14'h0;
		repeat (3) @(posedge clk_in);
		rd_chk(ba(IDX_EVST), 32'h1, "event status");
		@(negedge clk_in);
		chk({31'h0, irq_out}, 32'h0, "irq masked");
		wr(ba(IDX_EVMK), 32'h1);
		@(negedge clk_in);
		chk({31'h0, irq_out}, 32'h1, "irq raised");
		wr(ba(IDX_EVST), 32'h1);
		@(negedge clk_in);
		chk({31'h0, irq_out}, 32'h0, "irq cleared");
		rd_chk(ba(IDX_EVST), 32'h0, "event status cleared");
		$display("TEST event done");
		// Random writes with overlapping raises, and reads
		for (int n = 0; n < 300; n++) begin
			a = regs[$urandom_range(0, 4)];
			d = $urandom;
			if (a == ba(IDX_CLR2) || a == ba(IDX_MSK2)) d = d & 32'h3f;
			if (a == ba(IDX_SWEN)) d = d & 32'h1;
			if ($urandom_range(0, 2) != 0) begin
				fork
					wr(a, d);
					raise_at($urandom_range(0, 1) ? 14'($urandom) : 14'h0);
				join
			end else begin
				// Let the model settle on the last edge before taking its view
				@(negedge clk_in);
				rd_chk(a, exp_rd(a), "random read");
			end
		end
		$display("TEST random done");
		// Second reset in mid-run
		do_reset();
		rd_chk(ba(IDX_SWEN), 32'h0, "enable after reset");
		$display("TEST second reset done");
		finish_test();
	end
endmodule // tb_top
